/* rtl/prc_defines.svh */
`ifndef PRC_DEFINES_SVH
`define PRC_DEFINES_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define PRC_WINDOW_CTRL_OFS  12'h144
`define PRC_WINDOW_CTRL_RST  32'h0000_0000

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PRC_ENABLE_BIT       0
`define PRC_TYPE_BIT         1
`define PRC_LEN_LSB          2
`define PRC_LEN_MSB          4
`define PRC_MASK_LSB         8
`define PRC_MASK_MSB         18
`define PRC_BASE_LSB         20
`define PRC_BASE_MSB         30
`define PRC_WR_MASK          32'h7FF7_FF1F

// ----------------------------------------
// Bus command codes and responses
// ----------------------------------------
`define PRC_CMD_IO_RD        4'h2
`define PRC_CMD_IO_WR        4'h3
`define PRC_CMD_MEM_RD       4'h6
`define PRC_CMD_MEM_WR       4'h7
`define PRC_CMD_MEM_RD_MULT  4'hC
`define PRC_CMD_MEM_RD_LINE  4'hE
`define PRC_RESP_OKAY        2'h0
`define PRC_RESP_SLVERR      2'h2

// ----------------------------------------
// Prefetch length codes
// ----------------------------------------
`define PRC_LEN_MAX_CODE     3'h5
`define PRC_PLAIN_DWORDS     6'h01

`endif

/* rtl/prc_match.sv */
`include "prc_defines.svh"

module prc_match
	import prc_pkg::*;
(
	prc_match_if.dec  m
);
	// ----------------------------------------
	// Window compare
	// ----------------------------------------
	prc_win_t  diff;
	logic      in_win;
	logic      is_mem_rd;

	// Masked positions never count against the window
	assign diff      = (m.addr[30:20] ^ m.base) & ~m.mask;
	assign in_win    = (diff == '0);
	assign is_mem_rd = (m.cmd_in == `PRC_CMD_MEM_RD);
	assign m.hit     = m.enable & in_win;

	// ----------------------------------------
	// Command and length choice
	// ----------------------------------------
	always_comb begin
		m.cmd_out = m.cmd_in;
		m.dwords  = `PRC_PLAIN_DWORDS;
		if (is_mem_rd && m.hit) begin
			m.cmd_out = m.read_type ? `PRC_CMD_MEM_RD_MULT
			                        : `PRC_CMD_MEM_RD_LINE;
			// Reserved codes fall back to a single Dword
			if (m.len_code <= `PRC_LEN_MAX_CODE) begin
				m.dwords = 6'(1) << m.len_code;
			end
		end else if (is_mem_rd) begin
			m.cmd_out = `PRC_CMD_MEM_RD;
		end
	end
endmodule

/* rtl/prc_match_if.sv */
interface prc_match_if;
	import prc_pkg::*;
	logic            enable;
	logic            read_type;
	prc_len_t        len_code;
	prc_win_t        mask;
	prc_win_t        base;
	logic [30:0]     addr;
	logic [3:0]      cmd_in;
	logic            hit;
	logic [3:0]      cmd_out;
	logic [5:0]      dwords;

	modport ctrl (
		output enable, read_type, len_code, mask, base, addr, cmd_in,
		input  hit, cmd_out, dwords
	);
	modport dec (
		input  enable, read_type, len_code, mask, base, addr, cmd_in,
		output hit, cmd_out, dwords
	);
endinterface

/* rtl/prc_pkg.sv */
`include "prc_defines.svh"

package prc_pkg;
	typedef enum logic [3:0] {
		PRC_IO_RD        = `PRC_CMD_IO_RD,
		PRC_IO_WR        = `PRC_CMD_IO_WR,
		PRC_MEM_RD       = `PRC_CMD_MEM_RD,
		PRC_MEM_WR       = `PRC_CMD_MEM_WR,
		PRC_MEM_RD_MULT  = `PRC_CMD_MEM_RD_MULT,
		PRC_MEM_RD_LINE  = `PRC_CMD_MEM_RD_LINE
	} prc_cmd_t;

	typedef logic [10:0] prc_win_t;
	typedef logic [2:0]  prc_len_t;
endpackage

/* rtl/prc_sel.sv */
// The implementer's own choice: register access over AXI4-Lite.
`include "prc_defines.svh"

// Behaviour
// - With the window disabled nothing hits and every memory read goes out as plain memory read.
// - A hitting read uses memory read line when the type bit is 0 and memory read multiple when it is 1.
// - A hit prefetches at most 1, 2, 4, 8, 16 or 32 Dwords for codes 0 to 5; codes 6 and 7 are reserved.
// - Each set mask bit 18:8 removes address bit 30:20 in order from the compare.
// - The window spans 1MB with no mask bits up to 2GB with all of them set.
// - Address bits 30:20 are compared with the base field, masked positions ignored.
// - A memory read that misses an enabled compare issues the plain memory read command.
// - Address bit 31 comes from a separate extension bit and is outside the compare.
module prc_sel
	import prc_pkg::*;
#(
	parameter int ADDR_W = 12
)(
	input  wire logic               mclk,
	input  wire logic               srst,
	input  wire logic               ce,
	input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
	input  wire logic               s_axi_awvalid,
	output logic                    s_axi_awready,
	input  wire logic [31:0]        s_axi_wdata,
	input  wire logic [3:0]         s_axi_wstrb,
	input  wire logic               s_axi_wvalid,
	output logic                    s_axi_wready,
	output logic [1:0]              s_axi_bresp,
	output logic                    s_axi_bvalid,
	input  wire logic               s_axi_bready,
	input  wire logic [ADDR_W-1:0]  s_axi_araddr,
	input  wire logic               s_axi_arvalid,
	output logic                    s_axi_arready,
	output logic [31:0]             s_axi_rdata,
	output logic [1:0]              s_axi_rresp,
	output logic                    s_axi_rvalid,
	input  wire logic               s_axi_rready,
	input  wire logic               req_valid,
	input  wire logic [3:0]         req_cmd,
	input  wire logic [30:0]        req_addr,
	input  wire logic               addr_ext_hi,
	output logic                    out_valid,
	output logic [3:0]              out_cmd,
	output logic [31:0]             out_addr,
	output logic [5:0]              out_dwords,
	output logic                    out_hit
);
	// ----------------------------------------
	// Register and bus state
	// ----------------------------------------
	logic [31:0]        ctrl_r;
	logic [31:0]        ctrl_nxt;
	// Parked halves of a write
	logic               aw_held_r;
	logic [ADDR_W-1:0]  aw_addr_r;
	logic               w_held_r;
	logic [31:0]        w_data_r;
	logic [3:0]         w_strb_r;
	logic               do_write;
	logic               wr_hit;
	logic               rd_hit;
	logic               ctrl_we;
	logic               req_is_rd;
	logic [31:0]        wr_merge;

	// Decoder sees the register fields and the request directly
	prc_match_if  mif ();

	prc_match u_match (
		.m  (mif)
	);

	// ----------------------------------------
	// Write channel
	// ----------------------------------------
	// Address and data may arrive in either order; each is parked
	assign s_axi_awready = ~aw_held_r & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_held_r & ~s_axi_bvalid;
	assign do_write      = aw_held_r & w_held_r & ~s_axi_bvalid;
	assign wr_hit        = (aw_addr_r[ADDR_W-1:2] ==
	                        (ADDR_W-2)'(`PRC_WINDOW_CTRL_OFS >> 2));
	// Unmapped writes still answer, but never touch the register
	assign ctrl_we       = ce & do_write & wr_hit;

	always_ff @(posedge mclk) begin
		if (srst) begin
			aw_held_r <= 1'b0;
			aw_addr_r <= '0;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end else if (do_write) begin
				aw_held_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			w_held_r <= 1'b0;
			w_data_r <= '0;
			w_strb_r <= '0;
		end else if (ce) begin
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end else if (do_write) begin
				w_held_r <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Write response
	// ----------------------------------------
	// Store and response share an edge; a later read sees the new value
	always_ff @(posedge mclk) begin
		if (srst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `PRC_RESP_OKAY;
		end else if (ce) begin
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? `PRC_RESP_OKAY : `PRC_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Window control register
	// ----------------------------------------
	// Strobes pick lanes from the parked data, the rest keep old bits
	for (genvar i = 0; i < 4; i++) begin : g_lane
		assign wr_merge[i*8 +: 8] = w_strb_r[i] ? w_data_r[i*8 +: 8]
		                            : ctrl_r[i*8 +: 8];
	end

	// Read-only bits are cut here so they can never be stored
	assign ctrl_nxt = wr_merge & `PRC_WR_MASK;

	// Reserved length codes are kept as written; the decoder limits them
	always_ff @(posedge mclk) begin
		if (srst) begin
			ctrl_r <= `PRC_WINDOW_CTRL_RST;
		end else if (ctrl_we) begin
			ctrl_r <= ctrl_nxt;
		end
	end

	// ----------------------------------------
	// Read channel
	// ----------------------------------------
	// Only one read in flight: the answer must drain first
	assign s_axi_arready = ~s_axi_rvalid;
	assign rd_hit        = (s_axi_araddr[ADDR_W-1:2] ==
	                        (ADDR_W-2)'(`PRC_WINDOW_CTRL_OFS >> 2));

	// Unmapped reads answer zero with an error response
	always_ff @(posedge mclk) begin
		if (srst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= `PRC_RESP_OKAY;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_hit ? ctrl_r : '0;
				s_axi_rresp  <= rd_hit ? `PRC_RESP_OKAY
				                       : `PRC_RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Command selection path
	// ----------------------------------------
	assign mif.enable    = ctrl_r[`PRC_ENABLE_BIT];
	assign mif.read_type = ctrl_r[`PRC_TYPE_BIT];
	assign mif.len_code  = ctrl_r[`PRC_LEN_MSB:`PRC_LEN_LSB];
	assign mif.mask      = ctrl_r[`PRC_MASK_MSB:`PRC_MASK_LSB];
	assign mif.base      = ctrl_r[`PRC_BASE_MSB:`PRC_BASE_LSB];
	assign mif.addr      = req_addr;
	assign mif.cmd_in    = req_cmd;
	assign req_is_rd     = (req_cmd == `PRC_CMD_MEM_RD);

	// ----------------------------------------
	// Result registers
	// ----------------------------------------
	// One cycle of latency; valid copies req_valid and holds while ce is low
	always_ff @(posedge mclk) begin
		if (srst) begin
			out_valid <= 1'b0;
		end else if (ce) begin
			out_valid <= req_valid;
		end
	end

	// Results hold until the next request so a slow consumer can read them
	always_ff @(posedge mclk) begin
		if (srst) begin
			out_cmd    <= '0;
			out_addr   <= '0;
			out_dwords <= '0;
			out_hit    <= 1'b0;
		end else if (ce && req_valid) begin
			out_cmd    <= mif.cmd_out;
			// Bit 31 never enters the compare; it rides along
			out_addr   <= {addr_ext_hi, req_addr};
			out_dwords <= mif.dwords;
			// Hit is only reported for plain memory reads
			out_hit    <= mif.hit & req_is_rd;
		end
	end
endmodule

/* testbench/prc_pci_tgt.sv */
module prc_pci_tgt
	import prc_pkg::*;
(
	input wire logic       mclk,
	input wire logic       ce,
	input wire logic       out_valid,
	input wire logic [3:0] out_cmd,
	input wire logic [5:0] out_dwords
);
	timeunit 1ns;
	timeprecision 1ns;
	int n = 0;
	int sdw = 0;
	int nh = 0;
	// Target tallies accesses, burst sizes and prefetching commands
	always @(posedge mclk) begin
		if (ce && out_valid) begin
			n <= n + 1;
			sdw <= sdw + int'(out_dwords);
			if (out_cmd inside {PRC_MEM_RD_LINE, PRC_MEM_RD_MULT})
				nh <= nh + 1;
		end
	end
endmodule

/* testbench/prc_sel_sva.sv */
module prc_sel_sva
	import prc_pkg::*;
(
	input wire logic        mclk,
	input wire logic        srst,
	input wire logic        ce,
	input wire logic        req_valid,
	input wire logic [3:0]  req_cmd,
	input wire logic [30:0] req_addr,
	input wire logic        addr_ext_hi,
	input wire logic        out_valid,
	input wire logic [3:0]  out_cmd,
	input wire logic [31:0] out_addr,
	input wire logic [5:0]  out_dwords,
	input wire logic        out_hit,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	sequence s_rd_req;
		ce && req_valid && req_cmd == PRC_MEM_RD;
	endsequence
	sequence s_plain;
		out_cmd == PRC_MEM_RD && out_dwords == 6'h01;
	endsequence
	a_out_pulse: assert property (ce && req_valid |=> out_valid)
		else $error("no result after request");
	a_no_extra: assert property (ce && !req_valid |=> !out_valid)
		else $error("result without request");
	a_ce_hold: assert property (!ce |=>
		$stable(out_valid) && $stable(out_addr))
		else $error("outputs moved while clock enable low");
	a_addr_ext: assert property (ce && req_valid |=>
		out_addr[31] == $past(addr_ext_hi) && out_addr[30:0] == $past(req_addr))
		else $error("address bit 31 not from extension");
	a_pass_thru: assert property (
		ce && req_valid && req_cmd != PRC_MEM_RD |=>
		!out_hit && out_cmd == $past(req_cmd) && out_dwords == 6'h01)
		else $error("non-read access altered");
	a_read_miss: assert property (s_rd_req ##1 !out_hit |-> s_plain)
		else $error("missing read not plain");
	a_hit_cmd: assert property (out_valid && out_hit |->
		out_cmd inside {PRC_MEM_RD_LINE, PRC_MEM_RD_MULT})
		else $error("hit with wrong command");
	a_hit_len: assert property (out_valid && out_hit |-> $onehot(out_dwords))
		else $error("prefetch length not a power of two");
	a_rd_answer: assert property (ce && s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid)
		else $error("read answer late");
endmodule

bind prc_sel prc_sel_sva u_sva (
	.mclk, .srst, .ce, .req_valid, .req_cmd, .req_addr, .addr_ext_hi,
	.out_valid, .out_cmd, .out_addr, .out_dwords, .out_hit, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid
);

/* testbench/tb_prefetch_range_read_cmd_select.sv */
`include "prc_defines.svh"
module tb_prefetch_range_read_cmd_select;
	import prc_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 0, srst = 1, ce = 1, req_valid = 0, addr_ext_hi = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, out_valid, out_hit;
	logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, out_addr, d;
	logic [3:0] s_axi_wstrb = 0, req_cmd = 0, out_cmd;
	logic [30:0] req_addr = 0, a;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [5:0] out_dwords;
	logic [3:0] cmds [4] = '{PRC_MEM_RD, PRC_MEM_WR, PRC_IO_RD, PRC_IO_WR};
	int err_total = 0, compares = 0, cyc = 0, seed = 32'h3fb5_e771;
	int rv = 0, n = 0, sdw = 0, nh = 0;
	logic [3:0] st = 4'hf;

	prc_sel u_dut (.mclk, .srst, .ce, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .req_valid, .req_cmd,
		.req_addr, .addr_ext_hi, .out_valid, .out_cmd, .out_addr,
		.out_dwords, .out_hit);
	prc_pci_tgt u_tgt (.mclk, .ce, .out_valid, .out_cmd, .out_dwords);

	initial forever #50 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			wrap_up();
		end
	end

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wrap_up;
		$display("errors %0d compares %0d", err_total, compares);
		if (err_total == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic axi_wr(input logic [11:0] ad, input logic [31:0] dt,
		input logic [1:0] r);
		s_axi_awaddr <= ad;
		s_axi_wdata <= dt;
		s_axi_wstrb <= st;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge mclk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 0;
		chk(s_axi_bresp, r);
	endtask
	task automatic axi_rd(input logic [11:0] ad, input logic [31:0] dt,
		input logic [1:0] r);
		s_axi_araddr <= ad;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(posedge mclk);
			if (s_axi_arready) s_axi_arvalid <= 0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 0;
		chk({s_axi_rresp, s_axi_rdata}, {r, dt});
	endtask

	task automatic cls(input logic [3:0] c, input logic [30:0] ad, input x);
		int h, dw, oc;
		h = rv[0] && c == PRC_MEM_RD &&
			((((ad >> 20) ^ (rv >> 20)) & ~(rv >> 8)) & 'h7ff) == 0;
		dw = (h && rv[4:2] < 6) ? 1 << rv[4:2] : 1;
		oc = !h ? c : rv[1] ? PRC_MEM_RD_MULT : PRC_MEM_RD_LINE;
		req_cmd <= c;
		req_addr <= ad;
		addr_ext_hi <= x;
		req_valid <= 1;
		@(posedge mclk);
		req_valid <= 0;
		@(posedge mclk);
		chk({out_valid, out_hit, out_cmd, out_dwords, out_addr},
			{1'b1, h[0], oc[3:0], dw[5:0], x, ad});
		n++;
		sdw += dw;
		nh += h;
	endtask

	initial begin
		repeat (10) @(posedge mclk);
		srst <= 0;
		axi_rd(`PRC_WINDOW_CTRL_OFS, 32'h0, 2'h0);
		cls(PRC_MEM_RD, 31'h0, 1'b0);
		req_addr <= 31'h0123_4567;
		req_valid <= 1;
		@(posedge mclk);
		req_addr <= 31'h7654_3210;
		ce <= 0;
		@(posedge mclk);
		ce <= 1;
		req_valid <= 0;
		@(posedge mclk);
		chk({out_valid, out_addr}, {1'b1, 32'h0123_4567});
		n++;
		sdw++;
		axi_wr(12'h148, 32'hffff_ffff, 2'h2);
		axi_rd(12'h148, 32'h0, 2'h2);
		axi_wr(`PRC_WINDOW_CTRL_OFS, 32'hffff_ffff, 2'h0);
		rv = 32'h7ff7_ff1f;
		axi_rd(`PRC_WINDOW_CTRL_OFS, rv, 2'h0);
		cls(PRC_MEM_RD, 31'(unsigned'($random(seed))), 1'b1);
		for (int i = 0; i < 32; i++) begin
			d = $random(seed);
			d[4:2] = i[2:0];
			d[1] = i[3];
			d[0] = i < 28;
			if (i[0]) d[18:8] = 11'h000;
			d[30:20] = d[30:20] & ~d[18:8];
			axi_wr(`PRC_WINDOW_CTRL_OFS, d, 2'h0);
			rv = d & 32'h7ff7_ff1f;
			axi_rd(`PRC_WINDOW_CTRL_OFS, rv, 2'h0);
			for (int j = 0; j < 8; j++) begin
				a = 31'(unsigned'($random(seed)));
				if (j[1]) a[30:20] = rv[30:20] ^ (a[30:20] & rv[18:8]);
				if (j == 4) a[30:20] = rv[30:20] ^ (rv[18:8] + 11'h001);
				cls(j[0] ? cmds[j[2:1]] : PRC_MEM_RD, a, j[2]);
			end
		end
		st = 4'h1;
		axi_wr(`PRC_WINDOW_CTRL_OFS, 32'hffff_ffff, 2'h0);
		st = 4'hf;
		rv = {rv[31:8], 8'h1f};
		axi_rd(`PRC_WINDOW_CTRL_OFS, rv, 2'h0);
		cls(PRC_MEM_RD, rv[30:0], 1'b1);
		srst <= 1;
		repeat (2) @(posedge mclk);
		srst <= 0;
		rv = 0;
		axi_rd(`PRC_WINDOW_CTRL_OFS, 32'h0, 2'h0);
		cls(PRC_MEM_RD, 31'h0, 1'b0);
		repeat (3) @(posedge mclk);
		chk({u_tgt.n, u_tgt.sdw}, {n, sdw});
		chk(u_tgt.nh, nh);
		wrap_up();
	end
endmodule
